// >>> shared/nrc_params.svh
// Offsets, field positions, reset values for the NMI control block.
// Assumes inclusion from the package, the design module and the bench only.
`ifndef NRC_PARAMS_SVH
`define NRC_PARAMS_SVH
`define NRC_OFF_NMI_CTRL   12'h000
`define NRC_OFF_LOCK       12'h004
`define NRC_OFF_CAUSE      12'h008
`define NRC_BIT_DEADMAN_TIMEOUT_FLAG       25
`define NRC_BIT_WATCHDOG_RUN_TIMEOUT_FLAG       24
`define NRC_BIT_SOFTWARE_NMI_TRIGGER      23
`define NRC_BIT_GEN        19
`define NRC_BIT_LVD        18
`define NRC_BIT_CF         17
`define NRC_BIT_WATCHDOG_SLEEP_TIMEOUT_FLAG       16
`define NRC_IMPL_MASK      32'h038fffff
`define NRC_FLAG_MASK      32'h030f0000
`define NRC_CNT_FLAG_MASK  32'h03000000
`define NRC_RESET_VAL      32'h00000000
`define NRC_UNLOCK_KEY1    32'haa996655
`define NRC_UNLOCK_KEY2    32'h556699aa
`define NRC_RST_PULSE      4'h4
`endif

// >>> shared/nrc_pkg.sv
// Types for the NMI control block.
// Assumes nrc_params.svh sits beside it.
`include "nrc_params.svh"
package nrc_pkg;
    typedef struct packed {
        logic deadman_timeout;
        logic watchdog_run_timeout;
        logic generic_event;
        logic low_voltage_event;
        logic clock_fail;
        logic clock_switch_start;
        logic watchdog_sleep_timeout;
    } nrc_events_t;
    typedef enum logic [2:0] {
        NRC_IDLE  = 3'b001,
        NRC_COUNT = 3'b010,
        NRC_RESET = 3'b100
    } nrc_state_t;
endpackage

// >>> hdl/nrc_nmi_ctrl.sv
// NMI control and status register with the NMI reset down-counter, APB slave.
// Assumes event inputs from other clock domains; each passes two flip-flops.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "nrc_params.svh"

// Operation
// - Deadman expiry sets bit 25, raises NMI, starts reset countdown.
// - Writing one to bit 25 acts exactly like a deadman expiry.
// - Watchdog run time-out sets bit 24, NMI; writing one does likewise.
// - Writing one to bit 23 raises an NMI; writing zero does nothing.
// - Generic event sets bit 19 and raises NMI; writing one does likewise.
// - Low-voltage event sets bit 18 and raises NMI; writing one does likewise.
// - Clock failure sets bit 17 and raises NMI; software reads and clears it.
// - Writing one to bit 17 raises NMI without any clock switch.
// - Bit 17 clears when a valid clock switch sequence begins.
// - Sleep watchdog time-out sets bit 16 and wakes; writing one raises NMI.
// - Bits 15:0 hold the countdown reload in system clock cycles.
// - Clearing the triggering flag before zero cancels the device reset.
// - Reload of zero gives device reset with no delay.
// - Counter decrements once per cycle after trigger; at zero, resets device.
// - Only deadman and run watchdog events start the countdown.
// - Bits 31:26 and 22:20 read zero and ignore writes.
module nrc_nmi_ctrl
    import nrc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Event sources, asynchronous levels
    input  wire nrc_events_t events_in,
    // Outputs to CPU and reset logic
    output logic             nmi_req,
    output logic             sleep_wake,
    output logic             device_reset
);
    nrc_events_t ev_s1_q, ev_s2_q, ev_s3_q;
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] cnt_q, cnt_d;
    logic [1:0]  unlock_q, unlock_d;
    logic [3:0]  rst_cnt_q, rst_cnt_d;
    logic        software_nmi_trigger_q, wake_q;
    logic [31:0] prdata_d;
    nrc_state_t  state_q, state_d;

    // Address match against one register offset
    function automatic logic nrc_hit(input logic [11:0] addr, input logic [11:0] off);
        return addr == off;
    endfunction

    // Any of the selected flag bits set
    function automatic logic nrc_any(input logic [31:0] word, input logic [31:0] mask);
        return |(word & mask);
    endfunction

    // Two-flop synchroniser for the asynchronous event levels
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
        end else begin
            ev_s1_q <= events_in;
            ev_s2_q <= ev_s1_q;
        end
    end

    // Delayed copy of the synchronised levels for edge detect
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ev_s3_q <= '0;
        end else begin
            ev_s3_q <= ev_s2_q;
        end
    end

    // Rising edges of synchronised events
    wire nrc_events_t ev_rise   = ev_s2_q & ~ev_s3_q;
    // Bus decode
    wire              acc       = psel && penable;
    wire              wr        = acc && pwrite;
    wire              hit_ctrl  = nrc_hit(paddr, `NRC_OFF_NMI_CTRL);
    wire              hit_lock  = nrc_hit(paddr, `NRC_OFF_LOCK);
    wire              hit_cause = nrc_hit(paddr, `NRC_OFF_CAUSE);
    wire              mapped    = hit_ctrl | hit_lock | hit_cause;
    wire              unlocked  = (unlock_q == 2'd2);
    wire              wr_ctrl   = wr && hit_ctrl && unlocked;
    wire [31:0]       wmask     = wr_ctrl ? (pwdata & `NRC_IMPL_MASK) : 32'h0;
    wire              sw_trig   = wr_ctrl && pwdata[`NRC_BIT_SOFTWARE_NMI_TRIGGER];
    // Countdown triggers: hardware edge or written one
    wire              cnt_trig  = ev_rise.deadman_timeout | ev_rise.watchdog_run_timeout |
                                  nrc_any(wmask, `NRC_CNT_FLAG_MASK);
    wire              cnt_flag  = nrc_any(ctrl_q, `NRC_CNT_FLAG_MASK);

    // Bus phase and status selection
    wire              setup     = psel && !penable;
    wire              rd_setup  = setup && !pwrite;
    wire              err_setup = setup && !mapped;
    wire              any_flag  = nrc_any(ctrl_d, `NRC_FLAG_MASK);
    wire              nmi_next  = any_flag | sw_trig | software_nmi_trigger_q;
    wire [15:0]       reload    = ctrl_d[15:0];
    wire              reload_0  = (reload == 16'h0);
    wire              cnt_last  = (cnt_q <= 16'h1);
    wire              rst_next  = (state_d == NRC_RESET);

    // Sticky flags: hardware set beats software clear
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = pwdata & `NRC_IMPL_MASK & ~(32'h1 << `NRC_BIT_SOFTWARE_NMI_TRIGGER);
        end
        if (ev_rise.clock_switch_start) begin
            ctrl_d[`NRC_BIT_CF] = 1'b0;
        end
        if (ev_rise.deadman_timeout) begin
            ctrl_d[`NRC_BIT_DEADMAN_TIMEOUT_FLAG] = 1'b1;
        end
        if (ev_rise.watchdog_run_timeout) begin
            ctrl_d[`NRC_BIT_WATCHDOG_RUN_TIMEOUT_FLAG] = 1'b1;
        end
        if (ev_rise.generic_event) begin
            ctrl_d[`NRC_BIT_GEN] = 1'b1;
        end
        if (ev_rise.low_voltage_event) begin
            ctrl_d[`NRC_BIT_LVD] = 1'b1;
        end
        if (ev_rise.clock_fail) begin
            ctrl_d[`NRC_BIT_CF] = 1'b1;
        end
        if (ev_rise.watchdog_sleep_timeout) begin
            ctrl_d[`NRC_BIT_WATCHDOG_SLEEP_TIMEOUT_FLAG] = 1'b1;
        end
    end

    // Unlock sequence: two key words in order, any other lock write relocks
    always_comb begin
        unlock_d = unlock_q;
        if (wr && hit_lock) begin
            if (pwdata == `NRC_UNLOCK_KEY1) begin
                unlock_d = 2'd1;
            end else if (pwdata == `NRC_UNLOCK_KEY2 && unlock_q == 2'd1) begin
                unlock_d = 2'd2;
            end else begin
                unlock_d = 2'd0;
            end
        end
    end

    // Countdown state machine
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        rst_cnt_d = rst_cnt_q;
        case (state_q)
            NRC_IDLE: begin
                if (cnt_trig) begin
                    cnt_d = reload;
                    if (reload_0) begin
                        state_d   = NRC_RESET;
                        rst_cnt_d = `NRC_RST_PULSE;
                    end else begin
                        state_d = NRC_COUNT;
                    end
                end
            end
            NRC_COUNT: begin
                if (!cnt_flag) begin
                    state_d = NRC_IDLE;
                end else if (cnt_last) begin
                    cnt_d     = 16'h0;
                    state_d   = NRC_RESET;
                    rst_cnt_d = `NRC_RST_PULSE;
                end else begin
                    cnt_d = cnt_q - 16'h1;
                end
            end
            NRC_RESET: begin
                if (rst_cnt_q == 4'h0) begin
                    state_d = NRC_IDLE;
                end else begin
                    rst_cnt_d = rst_cnt_q - 4'h1;
                end
            end
            default: state_d = NRC_IDLE;
        endcase
    end

    // Read data mux; unmapped reads zero with error
    always_comb begin
        prdata_d = 32'h0;
        if (hit_ctrl) begin
            prdata_d = ctrl_q & `NRC_IMPL_MASK;
        end else if (hit_lock) begin
            prdata_d = {31'h0, unlocked};
        end else if (hit_cause) begin
            prdata_d = {16'h0, cnt_q};
        end
    end

    // Control and status flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `NRC_RESET_VAL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Countdown state and reset pulse length
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q   <= NRC_IDLE;
            rst_cnt_q <= 4'h0;
        end else begin
            state_q   <= state_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // Reset delay down-counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 16'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Unlock progress
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            unlock_q <= 2'd0;
        end else begin
            unlock_q <= unlock_d;
        end
    end

    // Stretch of the software trigger to two cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            software_nmi_trigger_q <= 1'b0;
        end else begin
            software_nmi_trigger_q <= sw_trig;
        end
    end

    // Sleep time-out edge, staged toward the wake output
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= ev_rise.watchdog_sleep_timeout;
        end
    end

    // Read data, valid in the access cycle only
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else begin
            prdata <= rd_setup ? prdata_d : 32'h0;
        end
    end

    // Zero-wait ready and error for unmapped offsets
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= err_setup;
        end
    end

    // NMI request level toward the CPU
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nmi_req <= 1'b0;
        end else begin
            nmi_req <= nmi_next;
        end
    end

    // Wake pulse and device reset level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sleep_wake   <= 1'b0;
            device_reset <= 1'b0;
        end else begin
            sleep_wake   <= wake_q;
            device_reset <= rst_next;
        end
    end
endmodule

// >>> verif/nrc_nmi_props.sv
// Checker for the NMI control block, port relations only.
// Assumes it is bound to nrc_nmi_ctrl.
`timescale 1ns/1ps
module nrc_nmi_props
    import nrc_pkg::*;
(
    // Clock, reset, bus
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Events and outputs
    input wire nrc_events_t events_in,
    input wire logic        nmi_req,
    input wire logic        sleep_wake,
    input wire logic        device_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Bus timing, decode and status relations
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    a_unmapped_err: assert property (pready && paddr > 12'h008 |-> pslverr) else $error("no error");
    a_reserved_zero: assert property (pready && !pwrite && paddr == 12'h000 |->
        prdata[31:26] == 6'h00 && prdata[23:20] == 4'h0) else $error("reserved bits set");
    a_gen_nmi: assert property ($rose(events_in.generic_event) |-> ##[2:5] nmi_req) else $error("no nmi");
    a_sleep_wake: assert property ($rose(events_in.watchdog_sleep_timeout) |-> ##[2:5] sleep_wake)
        else $error("no wake");
    a_reset_len: assert property ($rose(device_reset) |-> device_reset [*5] ##1 !device_reset)
        else $error("reset length");
    a_reset_nmi: assert property ($rose(device_reset) |-> nmi_req) else $error("reset without nmi");
    // Main scenarios
    c_reset: cover property ($rose(device_reset));
    c_wake: cover property (sleep_wake);
    c_err: cover property (pready && pslverr);
endmodule

// >>> verif/nrc_event_src.sv
// Event sources beside the block: timers, detectors, clock monitor.
// Assumes a one-cycle request pattern from the bench.
`timescale 1ns/1ps
module nrc_event_src
    import nrc_pkg::*;
(
    // Clock and requests
    input wire logic        clk,
    input wire nrc_events_t fire,
    // Levels toward the block
    output nrc_events_t     ev
);
    logic [2:0] hold_q;
    // Hold each event level 6 cycles so the synchroniser sees it
    always @(posedge clk) begin
        if (fire != '0) begin
            ev     <= fire;
            hold_q <= 3'h5;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end else begin
            ev <= '0;
        end
    end
endmodule

// >>> verif/test_nmi_control_reset_counter.sv
// Self-checking bench for the NMI control block over APB.
// Assumes nrc_nmi_ctrl, nrc_event_src and nrc_nmi_props are compiled.
`timescale 1ns/1ps
`include "nrc_params.svh"
module test_nmi_control_reset_counter;
    import nrc_pkg::*;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, nmi_req, sleep_wake, device_reset, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    nrc_events_t fire, ev;
    int          mismatches, n_tests, c, n;
    int          n_wake = 0;
    int          fbit [4] = '{19, 18, 17, 16};
    nrc_nmi_ctrl i_nrc_nmi_ctrl (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events_in(ev),
        .nmi_req(nmi_req), .sleep_wake(sleep_wake), .device_reset(device_reset));
    nrc_event_src i_nrc_event_src (.clk(clk), .fire(fire), .ev(ev));
    task test_done;
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Count wake pulses seen at rising edges
    always @(posedge clk) begin
        if (sleep_wake === 1'b1) n_wake <= n_wake + 1;
    end
    // One APB transfer; ready and data are taken at the rising edge, then released
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            test_done();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_rst(input int lim);
        c = 0;
        while (device_reset !== 1'b1 && c < lim) begin
            @(negedge clk);
            c++;
        end
    endtask
    task ev_fire(input nrc_events_t f);
        fire <= f;
        @(posedge clk);
        fire <= '0;
        repeat (8) @(posedge clk);
    endtask
    function logic [31:0] rd_exp(input logic [31:0] w);
        return w & 32'h030fffff;
    endfunction
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, fire, mismatches, n_tests} = '0;
        void'($urandom(36986));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, 12'h000, 32'h0300ffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        apb(1'b1, `NRC_OFF_LOCK, `NRC_UNLOCK_KEY1);
        apb(1'b1, `NRC_OFF_LOCK, `NRC_UNLOCK_KEY2);
        apb(1'b1, 12'h000, '1);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, rd_exp('1));
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h0f0, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        // Random reload: deadman write fires, then run watchdog write is aborted
        n = 4 + $urandom_range(40);
        apb(1'b1, 12'h000, 32'h02000000 | 32'(n));
        wait_rst(n + 8);
        chk(32'(c >= n - 2 && c <= n + 2), 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h02000000 | 32'(n));
        apb(1'b1, 12'h000, 32'(n));
        repeat (8) @(posedge clk);
        apb(1'b1, 12'h000, 32'h01000000 | 32'(n));
        apb(1'b1, 12'h000, 32'(n));
        wait_rst(n + 20);
        chk(32'(c), 32'(n + 20));
        apb(1'b1, 12'h000, 32'h02000000);
        wait_rst(4);
        chk(32'(c < 4), 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        repeat (8) @(posedge clk);
        // Flags that raise an NMI without a countdown
        foreach (fbit[k]) begin
            apb(1'b1, 12'h000, (32'h1 << fbit[k]) | 32'h3);
            wait_rst(10);
            chk(32'(c), 32'd10);
            chk({31'h0, nmi_req}, 32'h1);
            apb(1'b1, 12'h000, 32'h0);
        end
        apb(1'b1, 12'h000, 32'h00800000);
        @(negedge clk);
        chk({31'h0, nmi_req}, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        // Hardware events from the far side
        ev_fire(7'b0011001);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h000d0000);
        chk(32'(n_wake), 32'h1);
        ev_fire(7'b0000100);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h000f0000);
        ev_fire(7'b0000010);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h000d0000);
        apb(1'b1, 12'h000, 32'h0);
        fire <= 7'b1000000;
        wait_rst(12);
        chk(32'(c < 12), 32'h1);
        test_done();
    end
endmodule
bind nrc_nmi_ctrl nrc_nmi_props i_nrc_nmi_props (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events_in(events_in), .nmi_req(nmi_req), .sleep_wake(sleep_wake), .device_reset(device_reset));
